//--- rtl/sls_top.sv
// Purpose: serial link status register with interrupt and control registers
// Assumes: link state inputs synchronous to clk; AXI4-Lite master
// Notes:   page flag clears on read of the status word
`timescale 1ns/1ps
module sls_top
  import sls_pkg::*;
(
  input  wire  logic                  clk,
  input  wire  logic                  arst_n,
  input  wire  logic [sls_pkg::ADDR_W-1:0] s_awaddr,
  input  wire  logic                  s_awvalid,
  output logic                        s_awready,
  input  wire  logic [31:0]           s_wdata,
  input  wire  logic [3:0]            s_wstrb,
  input  wire  logic                  s_wvalid,
  output logic                        s_wready,
  output logic [1:0]                  s_bresp,
  output logic                        s_bvalid,
  input  wire  logic                  s_bready,
  input  wire  logic [sls_pkg::ADDR_W-1:0] s_araddr,
  input  wire  logic                  s_arvalid,
  output logic                        s_arready,
  output logic [31:0]                 s_rdata,
  output logic [1:0]                  s_rresp,
  output logic                        s_rvalid,
  input  wire  logic                  s_rready,
  input  wire  logic [1:0]            link_speed,
  input  wire  logic                  link_full_duplex,
  input  wire  logic                  link_up,
  input  wire  logic                  rx_sync,
  input  wire  logic                  page_rx,
  input  wire  logic                  an_complete,
  input  wire  logic                  bypass_timeout,
  input  wire  logic                  pause_tx_res,
  input  wire  logic                  pause_rx_res,
  output logic                        an_enable,
  output logic                        irq
);
  // ---------------------------------------------------------------
  // bus front end
  // ---------------------------------------------------------------
  logic                wr_stb, rd_stb;
  logic [ADDR_W-1:0]   wr_addr, rd_addr;
  logic [31:0]         wr_data, rd_data;
  logic [3:0]          wr_strb;
  logic                rd_err, wr_err;

  sls_axil_slave u_bus (
    .clk       (clk),
    .arst_n    (arst_n),
    .s_awaddr  (s_awaddr),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_wdata   (s_wdata),
    .s_wstrb   (s_wstrb),
    .s_wvalid  (s_wvalid),
    .s_wready  (s_wready),
    .s_bresp   (s_bresp),
    .s_bvalid  (s_bvalid),
    .s_bready  (s_bready),
    .s_araddr  (s_araddr),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rdata   (s_rdata),
    .s_rresp   (s_rresp),
    .s_rvalid  (s_rvalid),
    .s_rready  (s_rready),
    .wr_stb    (wr_stb),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .wr_strb   (wr_strb),
    .rd_stb    (rd_stb),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data),
    .rd_err    (rd_err),
    .wr_err    (wr_err)
  );

  // ---------------------------------------------------------------
  // resolution tracking
  // ---------------------------------------------------------------
  logic resolved, bypassed;
  logic [1:0] ctrl_q;

  assign an_enable = ctrl_q[B_AN_EN];

  sls_resolve u_res (
    .clk            (clk),
    .arst_n         (arst_n),
    .an_enable      (an_enable),
    .link_up        (link_up),
    .an_complete    (an_complete),
    .bypass_timeout (bypass_timeout),
    .resolved       (resolved),
    .bypassed       (bypassed)
  );

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire hit_wr_ctrl  = wr_stb && (wr_addr == OFF_CTRL) && wr_strb[0];
  wire hit_wr_stat  = wr_stb && (wr_addr == OFF_IRQ_STAT) && wr_strb[0];
  wire hit_wr_mask  = wr_stb && (wr_addr == OFF_IRQ_MASK) && wr_strb[0];
  wire wr_status    = wr_stb && (wr_addr == OFF_STATUS);
  wire rd_status    = rd_stb && (rd_addr == OFF_STATUS);
  wire wr_known     = (wr_addr == OFF_CTRL) || (wr_addr == OFF_IRQ_STAT) ||
                      (wr_addr == OFF_IRQ_MASK) || wr_status;
  wire rd_known     = (rd_addr == OFF_CTRL) || (rd_addr == OFF_IRQ_STAT) ||
                      (rd_addr == OFF_IRQ_MASK) || (rd_addr == OFF_STATUS);

  // status writes are accepted with OKAY but change nothing
  assign wr_err = !wr_known;
  assign rd_err = !rd_known;

  // ---------------------------------------------------------------
  // page flag, latched until the status word is read
  // ---------------------------------------------------------------
  logic page_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      page_q <= 1'b0;
    end else begin
      // a page landing on the read cycle survives into the next read
      page_q <= page_rx || (page_q && !rd_status);
    end
  end

  // ---------------------------------------------------------------
  // status word assembly
  // ---------------------------------------------------------------
  wire        fx_mode   = ctrl_q[B_FX_MODE];
  wire        pause_ok  = !fx_mode;
  logic [15:0] status_w;

  always_comb begin
    status_w                         = STATUS_RST;  // reserved bits zero
    status_w[B_SPEED_HI:B_SPEED_LO]  = link_speed;
    status_w[B_DUPLEX]               = link_full_duplex;
    status_w[B_PAGE]                 = page_q;
    status_w[B_RESOLVED]             = resolved;
    status_w[B_LINK]                 = link_up;
    status_w[B_BYPASS]               = bypassed;
    status_w[B_SYNC]                 = rx_sync;
    // pause results only reported, nothing here consumes them
    status_w[B_TXPAUSE]              = pause_tx_res && pause_ok;
    status_w[B_RXPAUSE]              = pause_rx_res && pause_ok;
  end

  // ---------------------------------------------------------------
  // control and interrupt registers
  // ---------------------------------------------------------------
  logic [IRQ_N-1:0] ist_q, imask_q, ev;
  logic             link_d1_q, res_d1_q;

  assign ev[I_PAGE]     = page_rx;
  assign ev[I_LINK]     = link_up != link_d1_q;
  assign ev[I_RESOLVED] = resolved && !res_d1_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q    <= CTRL_RST;
      imask_q   <= '0;
      ist_q     <= '0;
      link_d1_q <= 1'b0;
      res_d1_q  <= 1'b0;
    end else begin
      link_d1_q <= link_up;
      res_d1_q  <= resolved;
      if (hit_wr_ctrl) begin
        ctrl_q <= wr_data[1:0];
      end
      if (hit_wr_mask) begin
        imask_q <= wr_data[IRQ_N-1:0];
      end
      // set wins over a write-one clear in the same cycle
      ist_q <= ev | (ist_q & ~(hit_wr_stat ? wr_data[IRQ_N-1:0] : '0));
    end
  end

  assign irq = |(ist_q & imask_q);

  assign rd_data = (rd_addr == OFF_STATUS)   ? {16'h0000, status_w} :
                   (rd_addr == OFF_CTRL)     ? {30'h0, ctrl_q} :
                   (rd_addr == OFF_IRQ_STAT) ? {29'h0, ist_q} :
                   (rd_addr == OFF_IRQ_MASK) ? {29'h0, imask_q} : 32'h0;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_page_latch;
    @(posedge clk) disable iff (!arst_n) page_rx ##1 !rd_status |=> status_w[B_PAGE];
  endproperty
  a_page_latch: assert property (p_page_latch)
    else $error("page flag lost before being read");

  property p_page_clear;
    @(posedge clk) disable iff (!arst_n) rd_status && !page_rx |=> !page_q;
  endproperty
  a_page_clear: assert property (p_page_clear)
    else $error("page flag not cleared by read");

  property p_fx_pause;
    @(posedge clk) disable iff (!arst_n) fx_mode |-> status_w[B_TXPAUSE:B_RXPAUSE] == 2'h0;
  endproperty
  a_fx_pause: assert property (p_fx_pause)
    else $error("pause bits nonzero in fx mode");

  property p_pause_pass;
    @(posedge clk) disable iff (!arst_n)
      !fx_mode |-> status_w[B_TXPAUSE] == pause_tx_res && status_w[B_RXPAUSE] == pause_rx_res;
  endproperty
  a_pause_pass: assert property (p_pause_pass)
    else $error("pause bits do not follow resolution");

  property p_speed;
    @(posedge clk) disable iff (!arst_n)
      rd_status |=> s_rvalid && s_rdata[B_SPEED_HI:B_SPEED_LO] == $past(link_speed)
                   && s_rdata[B_DUPLEX] == $past(link_full_duplex);
  endproperty
  a_speed: assert property (p_speed)
    else $error("speed or duplex misreported");

  property p_live;
    @(posedge clk) disable iff (!arst_n)
      rd_status |=> s_rdata[B_LINK] == $past(link_up) && s_rdata[B_SYNC] == $past(rx_sync);
  endproperty
  a_live: assert property (p_live)
    else $error("link or sync not live");

  property p_reserved;
    @(posedge clk) disable iff (!arst_n)
      rd_status |=> s_rdata[31:16] == 16'h0 && s_rdata[8:6] == 3'h0
                   && s_rdata[4] == 1'b0 && s_rdata[1:0] == 2'h0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved status bits nonzero");

  property p_resolved_when_off;
    @(posedge clk) disable iff (!arst_n) !an_enable && !bypassed |-> status_w[B_RESOLVED];
  endproperty
  a_resolved_when_off: assert property (p_resolved_when_off)
    else $error("resolved low with autoneg off");

  // ---------------------------------------------------------------
  // register checks
  // ---------------------------------------------------------------
  property p_irq_set_wins;
    @(posedge clk) disable iff (!arst_n)
      ev != '0 |=> (ist_q & $past(ev)) == $past(ev);
  endproperty
  a_irq_set_wins: assert property (p_irq_set_wins)
    else $error("interrupt event lost");

  property p_irq_clear;
    @(posedge clk) disable iff (!arst_n)
      hit_wr_stat && wr_data[I_PAGE] && !ev[I_PAGE] |=> !ist_q[I_PAGE];
  endproperty
  a_irq_clear: assert property (p_irq_clear)
    else $error("page status not cleared by write one");

  property p_ctrl_write;
    @(posedge clk) disable iff (!arst_n)
      hit_wr_ctrl |=> ctrl_q == $past(wr_data[1:0]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("control write lost");

  property p_status_wr_inert;
    @(posedge clk) disable iff (!arst_n)
      wr_status |=> $stable(ctrl_q) && $stable(imask_q);
  endproperty
  a_status_wr_inert: assert property (p_status_wr_inert)
    else $error("status write changed a register");
endmodule

//--- rtl/sls_pkg.sv
// Purpose: constants for the serial link status register block
// Assumes: one 20 MHz clock, AXI4-Lite register access
// Notes:   offsets are byte addresses on a 32-bit bus
package sls_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  IDX_STATUS   = 8'h11;
  localparam logic [7:0]  OFF_STATUS   = 8'h44;   // 4 * index
  localparam logic [7:0]  OFF_CTRL     = 8'h00;
  localparam logic [7:0]  OFF_IRQ_STAT = 8'h04;
  localparam logic [7:0]  OFF_IRQ_MASK = 8'h08;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  // ---------------------------------------------------------------
  // status fields
  // ---------------------------------------------------------------
  localparam int          B_SPEED_HI   = 15;
  localparam int          B_SPEED_LO   = 14;
  localparam int          B_DUPLEX     = 13;
  localparam int          B_PAGE       = 12;
  localparam int          B_RESOLVED   = 11;
  localparam int          B_LINK       = 10;
  localparam int          B_BYPASS     = 9;
  localparam int          B_SYNC       = 5;
  localparam int          B_TXPAUSE    = 3;
  localparam int          B_RXPAUSE    = 2;
  localparam logic [1:0]  SPEED_10     = 2'h0;
  localparam logic [1:0]  SPEED_100    = 2'h1;
  localparam logic [1:0]  SPEED_1000   = 2'h2;
  localparam logic [15:0] STATUS_RST   = 16'h0000;
  // ---------------------------------------------------------------
  // control and interrupt fields
  // ---------------------------------------------------------------
  localparam int          B_AN_EN      = 0;
  localparam int          B_FX_MODE    = 1;
  localparam logic [1:0]  CTRL_RST     = 2'h1;
  localparam int          IRQ_N        = 3;
  localparam int          I_PAGE       = 0;
  localparam int          I_LINK       = 1;
  localparam int          I_RESOLVED   = 2;
  typedef enum logic [1:0] {SLS_UP_NONE, SLS_UP_AN, SLS_UP_BYPASS} sls_up_t;
endpackage

//--- rtl/sls_axil_slave.sv
// Purpose: AXI4-Lite slave front end, one write and one read at a time
// Assumes: master keeps valid and payload until taken
// Notes:   exposes single-cycle write and read strobes to the register file
`timescale 1ns/1ps
module sls_axil_slave
  import sls_pkg::*;
(
  input  wire  logic                  clk,
  input  wire  logic                  arst_n,
  input  wire  logic [sls_pkg::ADDR_W-1:0] s_awaddr,
  input  wire  logic                  s_awvalid,
  output logic                        s_awready,
  input  wire  logic [31:0]           s_wdata,
  input  wire  logic [3:0]            s_wstrb,
  input  wire  logic                  s_wvalid,
  output logic                        s_wready,
  output logic [1:0]                  s_bresp,
  output logic                        s_bvalid,
  input  wire  logic                  s_bready,
  input  wire  logic [sls_pkg::ADDR_W-1:0] s_araddr,
  input  wire  logic                  s_arvalid,
  output logic                        s_arready,
  output logic [31:0]                 s_rdata,
  output logic [1:0]                  s_rresp,
  output logic                        s_rvalid,
  input  wire  logic                  s_rready,
  output logic                        wr_stb,
  output logic [sls_pkg::ADDR_W-1:0]  wr_addr,
  output logic [31:0]                 wr_data,
  output logic [3:0]                  wr_strb,
  output logic                        rd_stb,
  output logic [sls_pkg::ADDR_W-1:0]  rd_addr,
  input  wire  logic [31:0]           rd_data,
  input  wire  logic                  rd_err,
  input  wire  logic                  wr_err
);
  logic              aw_hold_q, w_hold_q;
  logic [ADDR_W-1:0] addr_q;
  logic [31:0]       data_q;
  logic [3:0]        strb_q;
  wire  aw_take = s_awvalid && s_awready;
  wire  w_take  = s_wvalid && s_wready;

  assign s_awready = !aw_hold_q && !s_bvalid;
  assign s_wready  = !w_hold_q && !s_bvalid;
  assign s_arready = !s_rvalid;
  assign wr_stb    = (aw_hold_q || aw_take) && (w_hold_q || w_take);
  assign rd_stb    = s_arvalid && s_arready;
  assign rd_addr   = s_araddr;
  // a channel taken in the strobe cycle is used straight off the bus,
  // otherwise the strobe would act on the previous write's address
  assign wr_addr   = aw_hold_q ? addr_q : s_awaddr;
  assign wr_data   = w_hold_q ? data_q : s_wdata;
  assign wr_strb   = w_hold_q ? strb_q : s_wstrb;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      addr_q    <= '0;
      data_q    <= '0;
      strb_q    <= '0;
      s_bvalid  <= 1'b0;
      s_bresp   <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        addr_q <= s_awaddr;
      end
      if (w_take) begin
        data_q <= s_wdata;
        strb_q <= s_wstrb;
      end
      aw_hold_q <= (aw_hold_q || aw_take) && !wr_stb;
      w_hold_q  <= (w_hold_q || w_take) && !wr_stb;
      if (wr_stb) begin
        s_bvalid <= 1'b1;
        s_bresp  <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_rvalid <= 1'b0;
      s_rdata  <= '0;
      s_rresp  <= RESP_OKAY;
    end else if (rd_stb) begin
      s_rvalid <= 1'b1;
      s_rdata  <= rd_data;
      s_rresp  <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end
endmodule

//--- rtl/sls_resolve.sv
// Purpose: tracks how the serial link came up and whether it is resolved
// Assumes: event inputs are single-cycle pulses from the link logic
// Notes:   bypass and resolved are mutually exclusive by construction
`timescale 1ns/1ps
module sls_resolve
  import sls_pkg::*;
(
  input  wire  logic clk,
  input  wire  logic arst_n,
  input  wire  logic an_enable,
  input  wire  logic link_up,
  input  wire  logic an_complete,
  input  wire  logic bypass_timeout,
  output logic       resolved,
  output logic       bypassed
);
  sls_up_t up_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      up_q <= SLS_UP_NONE;
    end else if (!link_up) begin
      up_q <= SLS_UP_NONE;
    end else if (bypass_timeout) begin
      up_q <= SLS_UP_BYPASS;
    end else if (an_complete) begin
      up_q <= SLS_UP_AN;
    end
  end

  assign bypassed = (up_q == SLS_UP_BYPASS);
  // bypass forces resolved low even with autoneg disabled
  assign resolved = !bypassed && (!an_enable || (up_q == SLS_UP_AN));

  property p_bypass_blocks_resolved;
    @(posedge clk) disable iff (!arst_n) bypassed |-> !resolved;
  endproperty
  a_bypass_blocks_resolved: assert property (p_bypass_blocks_resolved)
    else $error("resolved high while bypass set");

  property p_bypass_sets;
    @(posedge clk) disable iff (!arst_n) link_up && bypass_timeout ##1 link_up |-> bypassed;
  endproperty
  a_bypass_sets: assert property (p_bypass_sets)
    else $error("bypass not recorded after timer expiry");

  property p_an_clears_bypass;
    @(posedge clk) disable iff (!arst_n)
      link_up && an_complete && !bypass_timeout |=> !bypassed;
  endproperty
  a_an_clears_bypass: assert property (p_an_clears_bypass)
    else $error("bypass not cleared by autoneg completion");

  property p_an_off_resolved;
    @(posedge clk) disable iff (!arst_n) !an_enable && !bypassed |-> resolved;
  endproperty
  a_an_off_resolved: assert property (p_an_off_resolved)
    else $error("resolved low with autoneg disabled");
endmodule

//--- test/sls_link_model.sv
// Purpose: far-side link model raising link, sync and resolution events
// Assumes: bench sets the wanted link state and field values as levels
// Notes:   delay sets how slowly the link comes up, 0 is prompt
`timescale 1ns/1ps
module sls_link_model (
  input  wire  logic       clk,
  input  wire  logic       arst_n,
  input  wire  logic       up_req,
  input  wire  logic       via_bypass,
  input  wire  logic [3:0] delay,
  input  wire  logic       page_req,
  input  wire  logic [1:0] speed_in,
  input  wire  logic       duplex_in,
  input  wire  logic       ptx_in,
  input  wire  logic       prx_in,
  output logic [1:0]       link_speed,
  output logic             link_full_duplex,
  output logic             link_up,
  output logic             rx_sync,
  output logic             page_rx,
  output logic             an_complete,
  output logic             bypass_timeout,
  output logic             pause_tx_res,
  output logic             pause_rx_res
);
  logic [4:0] cnt_q;

  // sync on the first edge, link and one resolution event delay cycles later
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {link_speed, link_full_duplex, link_up, rx_sync, page_rx} <= 6'h0;
      {an_complete, bypass_timeout, pause_tx_res, pause_rx_res} <= 4'h0;
      cnt_q <= 5'h0;
    end else begin
      link_speed       <= speed_in;
      link_full_duplex <= duplex_in;
      pause_tx_res     <= ptx_in;
      pause_rx_res     <= prx_in;
      page_rx          <= page_req;
      an_complete      <= 1'b0;
      bypass_timeout   <= 1'b0;
      if (!up_req) begin
        link_up <= 1'b0;
        rx_sync <= 1'b0;
        cnt_q   <= 5'h0;
      end else if (cnt_q <= {1'b0, delay}) begin
        cnt_q   <= cnt_q + 5'h1;
        rx_sync <= 1'b1;
        if (cnt_q == {1'b0, delay}) begin
          link_up        <= 1'b1;
          bypass_timeout <= via_bypass;
          an_complete    <= !via_bypass;
        end
      end
    end
  end
endmodule

//--- test/sls_top_tb.sv
// Purpose: self-checking bench for the serial link status register block
// Assumes: AXI4-Lite answers arrive one cycle after the request is taken
// Notes:   readies are sampled at the falling edge, so the rising edge is predicted without races
`timescale 1ns/1ps
module sls_top_tb;
  import sls_pkg::*;
  logic        clk, arst_n, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic        s_arvalid, s_arready, s_rvalid, s_rready, irq, an_enable;
  logic [7:0]  s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata;
  logic [3:0]  s_wstrb, delay;
  logic [1:0]  s_bresp, s_rresp, link_speed, sp;
  logic        link_full_duplex, link_up, rx_sync, page_rx, an_complete, bypass_timeout;
  logic        pause_tx_res, pause_rx_res, up_req, via_bypass, page_req, dp, tx, rx;
  logic [33:0] exp_r[$];
  logic [1:0]  exp_b[$];
  int          error_cnt, comparisons;

  sls_top u_dut (.clk(clk), .arst_n(arst_n), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .link_speed(link_speed), .link_full_duplex(link_full_duplex), .link_up(link_up), .rx_sync(rx_sync),
    .page_rx(page_rx), .an_complete(an_complete), .bypass_timeout(bypass_timeout),
    .pause_tx_res(pause_tx_res), .pause_rx_res(pause_rx_res), .an_enable(an_enable), .irq(irq));
  sls_link_model u_link (.clk(clk), .arst_n(arst_n), .up_req(up_req), .via_bypass(via_bypass),
    .delay(delay), .page_req(page_req), .speed_in(sp), .duplex_in(dp), .ptx_in(tx), .prx_in(rx),
    .link_speed(link_speed), .link_full_duplex(link_full_duplex), .link_up(link_up), .rx_sync(rx_sync),
    .page_rx(page_rx), .an_complete(an_complete), .bypass_timeout(bypass_timeout),
    .pause_tx_res(pause_tx_res), .pause_rx_res(pause_rx_res));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // compare and verdict
  // ---------------------------------------------------------------
  task automatic chk_word(input string nm, input logic [33:0] e, input logic [33:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic print_verdict;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // answers are taken at the next rising edge, one note per answer
  always @(negedge clk) begin
    if (s_rvalid === 1'b1 && s_rready === 1'b1) chk_word("read", exp_r.pop_front(), {s_rresp, s_rdata});
    if (s_bvalid === 1'b1 && s_bready === 1'b1) chk_word("bresp", {32'h0, exp_b.pop_front()}, {32'h0, s_bresp});
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end
  // ---------------------------------------------------------------
  // bus and link tasks
  // ---------------------------------------------------------------
  function automatic logic [33:0] st(input logic [1:0] s, input logic d, pg, rs, ln, bp, sy, t, r);
    return {RESP_OKAY, 16'h0, s, d, pg, rs, ln, bp, 3'h0, sy, 1'b0, t, r, 2'h0};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw, w, ta, tw;
    int   n;
    exp_b.push_back(r);
    {aw, w, n} = '0;
    @(posedge clk);
    s_awaddr  <= a;
    s_wdata   <= d;
    s_awvalid <= 1'b1;
    s_wvalid  <= 1'b1;
    s_bready  <= 1'b1;
    while (!(aw && w) && n < 100) begin
      @(negedge clk);
      n++;
      ta = !aw && s_awready === 1'b1;
      tw = !w && s_wready === 1'b1;
      @(posedge clk);
      if (ta) s_awvalid <= 1'b0;
      if (tw) s_wvalid <= 1'b0;
      aw |= ta;
      w |= tw;
    end
    do begin @(negedge clk); n++; end while (s_bvalid !== 1'b1 && n < 200);
    @(posedge clk);
    s_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    exp_r.push_back(e);
    n = 0;
    @(posedge clk);
    s_araddr  <= a;
    s_arvalid <= 1'b1;
    s_rready  <= 1'b1;
    do begin @(negedge clk); n++; end while (s_arready !== 1'b1 && n < 100);
    @(posedge clk);
    s_arvalid <= 1'b0;
    do begin @(negedge clk); n++; end while (s_rvalid !== 1'b1 && n < 200);
    @(posedge clk);
    s_rready <= 1'b0;
  endtask
  task automatic up(input logic [1:0] s, input logic byp);
    int n;
    n = 0;
    @(posedge clk);
    sp         <= s;
    dp         <= 1'($urandom_range(1));
    tx         <= 1'($urandom_range(1));
    rx         <= 1'($urandom_range(1));
    delay      <= 4'($urandom_range(15));
    via_bypass <= byp;
    up_req     <= 1'b1;
    do begin @(negedge clk); n++; end while (link_up !== 1'b1 && n < 50);
    // resolution state lands one edge after the partner event
    repeat (2) @(posedge clk);
  endtask
  task automatic set_lvl(input logic u, input logic pg, input logic t, input logic r);
    @(posedge clk);
    up_req   <= u;
    page_req <= pg;
    tx       <= t;
    rx       <= r;
    @(posedge clk);
    page_req <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {arst_n, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, up_req, via_bypass, page_req} = '0;
    {s_awaddr, s_araddr, s_wdata, delay, sp, dp, tx, rx} = '0;
    s_wstrb     = 4'hf;
    error_cnt   = 0;
    comparisons = 0;
    void'($urandom(37548));
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    rd(OFF_STATUS, st(2'h0, 0, 0, 0, 0, 0, 0, 0, 0));
    rd(OFF_CTRL, {RESP_OKAY, 30'h0, CTRL_RST});
    rd(OFF_IRQ_MASK, {RESP_OKAY, 32'h0});
    rd(8'h40, {RESP_SLVERR, 32'h0});
    wr(8'h40, 32'hffff_ffff, RESP_SLVERR);
    wr(OFF_STATUS, 32'hffff_ffff, RESP_OKAY);
    rd(OFF_STATUS, st(2'h0, 0, 0, 0, 0, 0, 0, 0, 0));
    for (int i = 0; i < 3; i++) begin
      up(2'(i), 1'b0);
      rd(OFF_STATUS, st(sp, dp, 0, 1, 1, 0, 1, tx, rx));
      set_lvl(1'b0, 1'b0, tx, rx);
      rd(OFF_STATUS, st(sp, dp, 0, 0, 0, 0, 0, tx, rx));
    end
    up(SPEED_1000, 1'b1);
    rd(OFF_STATUS, st(sp, dp, 0, 0, 1, 1, 1, tx, rx));
    wr(OFF_CTRL, 32'h0, RESP_OKAY);
    @(negedge clk);
    chk_bit("an_enable", 1'b0, an_enable);
    rd(OFF_STATUS, st(sp, dp, 0, 0, 1, 1, 1, tx, rx));
    set_lvl(1'b0, 1'b0, tx, rx);
    rd(OFF_STATUS, st(sp, dp, 0, 1, 0, 0, 0, tx, rx));
    wr(OFF_CTRL, 32'h3, RESP_OKAY);
    up(SPEED_100, 1'b0);
    set_lvl(1'b1, 1'b0, 1'b1, 1'b1);
    rd(OFF_STATUS, st(sp, dp, 0, 1, 1, 0, 1, 0, 0));
    wr(OFF_CTRL, 32'h1, RESP_OKAY);
    rd(OFF_STATUS, st(sp, dp, 0, 1, 1, 0, 1, 1, 1));
    // earlier link events are cleared so only the page event remains
    wr(OFF_IRQ_STAT, 32'h7, RESP_OKAY);
    set_lvl(1'b1, 1'b1, 1'b1, 1'b1);
    @(negedge clk);
    chk_bit("irq", 1'b0, irq);
    rd(OFF_IRQ_STAT, {RESP_OKAY, 32'h1});
    wr(OFF_IRQ_MASK, 32'h1, RESP_OKAY);
    @(negedge clk);
    chk_bit("irq", 1'b1, irq);
    rd(OFF_STATUS, st(sp, dp, 1, 1, 1, 0, 1, 1, 1));
    rd(OFF_STATUS, st(sp, dp, 0, 1, 1, 0, 1, 1, 1));
    wr(OFF_IRQ_STAT, 32'h1, RESP_OKAY);
    @(negedge clk);
    chk_bit("irq", 1'b0, irq);
    rd(OFF_IRQ_STAT, {RESP_OKAY, 32'h0});
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rd(OFF_CTRL, {RESP_OKAY, 30'h0, CTRL_RST});
    rd(OFF_IRQ_MASK, {RESP_OKAY, 32'h0});
    print_verdict();
  end
endmodule
